// ---- bench/cig_core_model.sv ----
`timescale 1ns/1ns
module cig_core_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Controller side
  input wire logic irq_take,
  input wire logic ctx_restore,
  input wire cig_pkg::cig_ctx_t restore_ctx,
  input wire logic [7:0] svc_len,
  output cig_pkg::cig_ctx_t core_ctx,
  output logic [14:0] core_pc,
  output logic core_return
);
  import cig_pkg::*;
  logic busy;
  logic [7:0] cnt;
  // The routine trashes every live register so that a lost restore cannot hide.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      core_ctx <= '{w: 8'h5a, status: 8'hc3, bank_sel: 5'h15, ptr0: 16'h1234, ptr1: 16'habcd, pc_latch: 7'h2e};
    else if (ctx_restore)
      core_ctx <= restore_ctx;
    else if (busy)
      core_ctx <= cig_ctx_t'(~core_ctx);
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      core_pc <= 15'h0100;
    else if (!busy)
      core_pc <= core_pc + 15'h0001;
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      core_return <= 1'b0;
    end else begin
      core_return <= 1'b0;
      if (irq_take) begin
        busy <= 1'b1;
        cnt <= svc_len;
      end else if (busy && cnt <= 8'h01) begin
        busy <= 1'b0;
        core_return <= 1'b1;
      end else if (busy)
        cnt <= cnt - 8'h01;
    end
  end
endmodule

// ---- bench/cig_irq_gate_assertions.sv ----
`timescale 1ns/1ns
module cig_irq_gate_assertions #(
  parameter int PC_WIDTH = 15
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Watched ports
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [PC_WIDTH-1:0] core_pc,
  input wire logic core_return,
  input wire logic irq_take,
  input wire logic [PC_WIDTH-1:0] vector_addr,
  input wire logic stack_push,
  input wire logic [PC_WIDTH-1:0] push_pc,
  input wire logic stack_pop,
  input wire logic ctx_restore,
  input wire cig_pkg::cig_ctx_t restore_ctx
);
  import cig_pkg::*;
  logic in_svc;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      in_svc <= 1'b0;
    else if (irq_take)
      in_svc <= 1'b1;
    else if (stack_pop)
      in_svc <= 1'b0;
  end
  AST_TAKE_PUSH: assert property (irq_take == stack_push)
    else $error("push not paired with take");
  AST_PUSH_PC: assert property (irq_take |-> push_pc == $past(core_pc))
    else $error("wrong return address pushed");
  AST_VECTOR: assert property (irq_take |-> vector_addr == 15'h0004)
    else $error("wrong vector");
  AST_NO_NEST: assert property (in_svc |-> !irq_take)
    else $error("nested take");
  AST_POP_PAIR: assert property (stack_pop == ctx_restore)
    else $error("pop and restore apart");
  AST_POP_CAUSE: assert property (stack_pop |-> $past(core_return) && $past(in_svc))
    else $error("pop without return");
  AST_STATUS_MASK: assert property (ctx_restore |-> restore_ctx.status[4:3] == 2'b00)
    else $error("status bits restored");
  AST_RESET_QUIET: assert property ($rose(rst_b) |-> !irq_take && !stack_pop && !pready)
    else $error("activity after reset");
  COV_TAKE: cover property (irq_take);
  COV_POP: cover property (stack_pop);
  COV_SLVERR: cover property (pready && pslverr);
endmodule

// ---- bench/cig_irq_gate_tb_top.sv ----
`timescale 1ns/1ns
module cig_irq_gate_tb_top;
  import cig_pkg::*;
  logic sys_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic ext_irq_pin = 1'b1, timer0_ovf = 1'b0, slv_err;
  logic [7:0] paddr = 8'h00, pin_change_event = 8'h00, periph_flags = 8'h00, svc_len = 8'h02;
  logic [31:0] pwdata = 32'h0, prdata, v, d;
  logic pready, pslverr, irq_take, stack_push, stack_pop, ctx_restore, core_return;
  logic [14:0] core_pc, vector_addr, push_pc;
  cig_ctx_t core_ctx, restore_ctx, cap;
  int num_errors = 0, checked = 0, ntake = 0, cyc = 0, n;
  cig_irq_gate cig_irq_gate_inst (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_irq_pin, .timer0_ovf, .pin_change_event, .periph_flags, .core_ctx, .core_pc,
    .core_return, .irq_take, .vector_addr, .stack_push, .push_pc, .stack_pop, .ctx_restore, .restore_ctx);
  cig_core_model cig_core_model_inst (.sys_clk, .rst_b, .irq_take, .ctx_restore, .restore_ctx, .svc_len,
    .core_ctx, .core_pc, .core_return);
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (irq_take === 1'b1)
      ntake <= ntake + 1;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the bench timeout ends a transfer that never completes.
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, v);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, v);
    chk(v, e);
  endtask
  task automatic pulse_src(input logic t, input logic [7:0] p);
    @(posedge sys_clk);
    timer0_ovf <= t;
    pin_change_event <= p;
    @(posedge sys_clk);
    timer0_ovf <= 1'b0;
    pin_change_event <= 8'h00;
  endtask
  task automatic wait_for(input logic pop, output int k);
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while ((pop ? ctx_restore : irq_take) !== 1'b1 && k < 200);
    chk(k < 200, 1'b1);
  endtask
  function automatic cig_ctx_t exp_ctx(input cig_ctx_t c, input logic [7:0] w);
    cig_ctx_t r;
    r = c;
    r.w = w;
    r.status = c.status & CIG_STATUS_SAVE_MASK;
    return r;
  endfunction
  initial begin
    void'($urandom(20));
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    apb(1'b0, 8'h30, 32'h0, v);
    chk(slv_err, 1'b1);
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      wr(8'h04, d);
      rdc(8'h04, {24'h0, d[7:0]});
    end
    wr(8'h00, 32'h7f);
    rdc(8'h00, 32'h7e);
    wr(8'h00, 32'h0);
    $display("test registers done");
    pulse_src(1'b1, 8'h00);
    rdc(8'h00, 32'h04);
    @(posedge sys_clk);
    ext_irq_pin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rdc(8'h00, 32'h06);
    pulse_src(1'b0, 8'h08);
    rdc(8'h00, 32'h07);
    wr(8'h0c, 32'hf7);
    rdc(8'h00, 32'h06);
    wr(8'h00, 32'h0);
    chk(ntake, 0);
    $display("test flags done");
    svc_len <= 8'h3c;
    wr(8'h00, 32'ha0);
    pulse_src(1'b1, 8'h00);
    wait_for(1'b0, n);
    cap = core_ctx;
    chk(n < 20, 1'b1);
    d = $urandom;
    rdc(8'h00, 32'h24);
    rdc(8'h28, 32'h2);
    rdc(8'h14, {24'h0, cap.status & CIG_STATUS_SAVE_MASK});
    wr(8'h10, d);
    rdc(8'h10, {24'h0, d[7:0]});
    wr(8'h00, 32'h20);
    wait_for(1'b1, n);
    chk(restore_ctx, exp_ctx(cap, d[7:0]));
    rdc(8'h00, 32'ha0);
    $display("test timer take done");
    svc_len <= 8'h28;
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h90);
    @(posedge sys_clk);
    ext_irq_pin <= 1'b1;
    wait_for(1'b0, n);
    chk(n inside {[4:6]}, 1'b1);
    wr(8'h00, 32'h10);
    wait_for(1'b1, n);
    repeat (10) @(posedge sys_clk);
    chk(ntake, 2);
    $display("test pin take done");
    svc_len <= 8'h02 + 8'($urandom % 10);
    wr(8'h04, 32'h40);
    periph_flags <= 8'h40;
    wr(8'h00, 32'h80);
    repeat (8) @(posedge sys_clk);
    chk(ntake, 2);
    wr(8'h00, 32'hc0);
    wait_for(1'b0, n);
    periph_flags <= 8'h00;
    chk(n < 20, 1'b1);
    wait_for(1'b1, n);
    $display("test peripheral gate done");
    svc_len <= 8'h3c;
    wr(8'h00, 32'h08);
    pulse_src(1'b0, 8'h01);
    repeat (4) @(posedge sys_clk);
    chk(ntake, 3);
    wr(8'h00, 32'h88);
    wait_for(1'b0, n);
    chk(n < 20, 1'b1);
    wr(8'h0c, 32'hfe);
    wait_for(1'b1, n);
    rdc(8'h00, 32'h88);
    $display("test pin change take done");
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    $display("test second reset done");
    give_verdict();
  end
endmodule
bind cig_irq_gate cig_irq_gate_assertions #(.PC_WIDTH(PC_WIDTH)) cig_irq_gate_assertions_inst (.sys_clk,
  .rst_b, .pready, .pslverr, .core_pc, .core_return, .irq_take, .vector_addr, .stack_push, .push_pc,
  .stack_pop, .ctx_restore, .restore_ctx);

// ---- rtl/cig_irq_gate.sv ----
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ns
module cig_irq_gate #(
  parameter int PIN_CHANGE_WIDTH = 8,
  parameter int PC_WIDTH = 15
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt sources
  input wire logic ext_irq_pin,
  input wire logic timer0_ovf,
  input wire logic [PIN_CHANGE_WIDTH-1:0] pin_change_event,
  input wire logic [7:0] periph_flags,
  // Processor core
  input wire cig_pkg::cig_ctx_t core_ctx,
  input wire logic [PC_WIDTH-1:0] core_pc,
  input wire logic core_return,
  output logic irq_take,
  output logic [PC_WIDTH-1:0] vector_addr,
  output logic stack_push,
  output logic [PC_WIDTH-1:0] push_pc,
  output logic stack_pop,
  output logic ctx_restore,
  output cig_pkg::cig_ctx_t restore_ctx
);
  import cig_pkg::*;

  logic [7:0] irq_control_reg;
  logic [7:0] periph_enable_reg_1;
  logic ext_edge_select;
  logic [PIN_CHANGE_WIDTH-1:0] pin_change_flag_regs;
  cig_ctx_t shadow;
  cig_state_t state;
  cig_state_t next_state;

  logic pin_sync1;
  logic pin_sync2;
  logic pin_prev;
  logic ext_edge;

  logic access;
  logic wr_en;
  logic [31:0] next_rdata;
  logic next_err;
  logic pending;
  logic take_now;
  logic pin_change_flag;
  logic [7:0] control_view;

  // Access phase completes at the edge where the registered pready is high.
  assign access = psel && penable && pready;
  assign wr_en = access && pwrite;

  // The pin is asynchronous; only the second stage feeds the edge detector.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_sync1 <= 1'b0;
      pin_sync2 <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_sync1 <= ext_irq_pin;
      pin_sync2 <= pin_sync1;
      pin_prev <= pin_sync2;
    end
  end

  // Polarity choice picks which transition counts as the event.
  always_comb begin
    if (ext_edge_select) begin
      ext_edge = pin_sync2 && !pin_prev;
    end else begin
      ext_edge = !pin_sync2 && pin_prev;
    end
  end

  // Summary flag follows the individual flags and cannot be written.
  assign pin_change_flag = |pin_change_flag_regs;

  always_comb begin
    control_view = irq_control_reg;
    control_view[CIG_BIT_PIN_CHG_FLAG] = pin_change_flag;
  end

  // Request combines every flag with its own enable and the gates above it.
  always_comb begin
    pending = 1'b0;
    if (irq_control_reg[CIG_BIT_EXT_EN] && irq_control_reg[CIG_BIT_EXT_FLAG]) begin
      pending = 1'b1;
    end
    if (irq_control_reg[CIG_BIT_TIMER0_EN] && irq_control_reg[CIG_BIT_TIMER0_FLAG]) begin
      pending = 1'b1;
    end
    if (irq_control_reg[CIG_BIT_PIN_CHG_EN] && pin_change_flag) begin
      pending = 1'b1;
    end
    if (irq_control_reg[CIG_BIT_PERIPH_GATE] && |(periph_enable_reg_1 & periph_flags)) begin
      pending = 1'b1;
    end
  end

  // Nothing is taken until software has set the global enable.
  assign take_now = (state == CIG_ST_RUN) && irq_control_reg[CIG_BIT_GLOBAL] && pending;

  always_comb begin
    next_state = state;
    case (state)
      CIG_ST_RUN: begin
        if (take_now) begin
          next_state = CIG_ST_ENTRY;
        end
      end
      CIG_ST_ENTRY: begin
        next_state = CIG_ST_SERVICE;
      end
      CIG_ST_SERVICE: begin
        if (core_return) begin
          next_state = CIG_ST_RUN;
        end
      end
      default: begin
        next_state = CIG_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= CIG_ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Control register: hardware sets win over a software clear in the same cycle,
  // and taking an interrupt wins over a software write of the global enable.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_control_reg <= CIG_RST_IRQ_CONTROL;
    end else begin
      if (wr_en && paddr == CIG_OFS_IRQ_CONTROL) begin
        irq_control_reg[7:1] <= pwdata[7:1];
      end
      if (ext_edge) begin
        irq_control_reg[CIG_BIT_EXT_FLAG] <= 1'b1;
      end
      if (timer0_ovf) begin
        irq_control_reg[CIG_BIT_TIMER0_FLAG] <= 1'b1;
      end
      if (take_now) begin
        irq_control_reg[CIG_BIT_GLOBAL] <= 1'b0;
      end else if (core_return && state == CIG_ST_SERVICE) begin
        irq_control_reg[CIG_BIT_GLOBAL] <= 1'b1;
      end
      irq_control_reg[CIG_BIT_PIN_CHG_FLAG] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      periph_enable_reg_1 <= CIG_RST_PERIPH_ENABLE_1;
    end else if (wr_en && paddr == CIG_OFS_PERIPH_ENABLE_1) begin
      periph_enable_reg_1 <= pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_edge_select <= 1'b0;
    end else if (wr_en && paddr == CIG_OFS_EDGE_SELECT) begin
      ext_edge_select <= pwdata[0];
    end
  end

  // Writing zero clears an individual flag; a new event in that cycle survives.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_change_flag_regs <= '0;
    end else if (wr_en && paddr == CIG_OFS_PIN_CHANGE_FLAGS) begin
      pin_change_flag_regs <= (pin_change_flag_regs & pwdata[PIN_CHANGE_WIDTH-1:0]) | pin_change_event;
    end else begin
      pin_change_flag_regs <= pin_change_flag_regs | pin_change_event;
    end
  end

  // Shadow copies: the entry capture overrides a software write in the same cycle.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      shadow <= '0;
    end else if (take_now) begin
      shadow <= core_ctx;
      shadow.status <= core_ctx.status & CIG_STATUS_SAVE_MASK;
    end else if (wr_en) begin
      if (paddr == CIG_OFS_SHADOW_W) begin
        shadow.w <= pwdata[7:0];
      end else if (paddr == CIG_OFS_SHADOW_STATUS) begin
        shadow.status <= pwdata[7:0] & CIG_STATUS_SAVE_MASK;
      end else if (paddr == CIG_OFS_SHADOW_BANK) begin
        shadow.bank_sel <= pwdata[4:0];
      end else if (paddr == CIG_OFS_SHADOW_PTR0) begin
        shadow.ptr0 <= pwdata[15:0];
      end else if (paddr == CIG_OFS_SHADOW_PTR1) begin
        shadow.ptr1 <= pwdata[15:0];
      end else if (paddr == CIG_OFS_SHADOW_PC_LATCH) begin
        shadow.pc_latch <= pwdata[6:0];
      end
    end
  end

  // Core side: every strobe is a one-cycle pulse from a flip-flop.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_take <= 1'b0;
      vector_addr <= '0;
      stack_push <= 1'b0;
      push_pc <= '0;
    end else begin
      irq_take <= take_now;
      stack_push <= take_now;
      if (take_now) begin
        vector_addr <= CIG_VECTOR_ADDR[PC_WIDTH-1:0];
        push_pc <= core_pc;
      end
    end
  end

  // The return strobe is honoured only inside a service routine.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stack_pop <= 1'b0;
      ctx_restore <= 1'b0;
      restore_ctx <= '0;
    end else begin
      stack_pop <= core_return && state == CIG_ST_SERVICE;
      ctx_restore <= core_return && state == CIG_ST_SERVICE;
      if (core_return && state == CIG_ST_SERVICE) begin
        restore_ctx <= shadow;
      end
    end
  end

  // Read mux and unmapped-address detection.
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    if (paddr == CIG_OFS_IRQ_CONTROL) begin
      next_rdata[7:0] = control_view;
    end else if (paddr == CIG_OFS_PERIPH_ENABLE_1) begin
      next_rdata[7:0] = periph_enable_reg_1;
    end else if (paddr == CIG_OFS_EDGE_SELECT) begin
      next_rdata[0] = ext_edge_select;
    end else if (paddr == CIG_OFS_PIN_CHANGE_FLAGS) begin
      next_rdata[PIN_CHANGE_WIDTH-1:0] = pin_change_flag_regs;
    end else if (paddr == CIG_OFS_SHADOW_W) begin
      next_rdata[7:0] = shadow.w;
    end else if (paddr == CIG_OFS_SHADOW_STATUS) begin
      next_rdata[7:0] = shadow.status;
    end else if (paddr == CIG_OFS_SHADOW_BANK) begin
      next_rdata[4:0] = shadow.bank_sel;
    end else if (paddr == CIG_OFS_SHADOW_PTR0) begin
      next_rdata[15:0] = shadow.ptr0;
    end else if (paddr == CIG_OFS_SHADOW_PTR1) begin
      next_rdata[15:0] = shadow.ptr1;
    end else if (paddr == CIG_OFS_SHADOW_PC_LATCH) begin
      next_rdata[6:0] = shadow.pc_latch;
    end else if (paddr == CIG_OFS_SERVICE_STATE) begin
      next_rdata[1:0] = state;
    end else begin
      next_err = 1'b1;
    end
  end

  // One wait state: pready is registered high in the second access cycle, so read data is
  // sampled from a register and the decode never sits on the output path.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : next_rdata;
        pslverr <= next_err;
      end else begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

endmodule

// ---- rtl/cig_pkg.sv ----
package cig_pkg;

  localparam logic [7:0] CIG_OFS_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] CIG_OFS_PERIPH_ENABLE_1 = 8'h04;
  localparam logic [7:0] CIG_OFS_EDGE_SELECT = 8'h08;
  localparam logic [7:0] CIG_OFS_PIN_CHANGE_FLAGS = 8'h0c;
  localparam logic [7:0] CIG_OFS_SHADOW_W = 8'h10;
  localparam logic [7:0] CIG_OFS_SHADOW_STATUS = 8'h14;
  localparam logic [7:0] CIG_OFS_SHADOW_BANK = 8'h18;
  localparam logic [7:0] CIG_OFS_SHADOW_PTR0 = 8'h1c;
  localparam logic [7:0] CIG_OFS_SHADOW_PTR1 = 8'h20;
  localparam logic [7:0] CIG_OFS_SHADOW_PC_LATCH = 8'h24;
  localparam logic [7:0] CIG_OFS_SERVICE_STATE = 8'h28;

  localparam int CIG_BIT_GLOBAL = 7;
  localparam int CIG_BIT_PERIPH_GATE = 6;
  localparam int CIG_BIT_TIMER0_EN = 5;
  localparam int CIG_BIT_EXT_EN = 4;
  localparam int CIG_BIT_PIN_CHG_EN = 3;
  localparam int CIG_BIT_TIMER0_FLAG = 2;
  localparam int CIG_BIT_EXT_FLAG = 1;
  localparam int CIG_BIT_PIN_CHG_FLAG = 0;

  localparam int CIG_BIT_TIMEOUT = 4;
  localparam int CIG_BIT_POWERDOWN = 3;
  localparam logic [7:0] CIG_STATUS_SAVE_MASK = 8'he7;

  localparam logic [7:0] CIG_RST_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] CIG_RST_PERIPH_ENABLE_1 = 8'h00;
  localparam logic [14:0] CIG_VECTOR_ADDR = 15'h0004;

  typedef struct packed {
    logic [7:0] w;
    logic [7:0] status;
    logic [4:0] bank_sel;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [6:0] pc_latch;
  } cig_ctx_t;

  typedef enum logic [1:0] {
    CIG_ST_RUN = 2'b00,
    CIG_ST_ENTRY = 2'b01,
    CIG_ST_SERVICE = 2'b10
  } cig_state_t;

endpackage
